//--- common/isas_pkg.sv
// Constants, states and commands shared by both ends of the two-wire slave link.
// Assumes both ends run on one core clock of the rate given below.
package isas_pkg;

  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  localparam logic [3:0] LAST_DATA_CNT = 4'h8;
  localparam logic [3:0] ACK_BIT_CNT = 4'h9;
  localparam logic CLOCK_RELEASE_RESET = 1'h1;
  localparam logic [7:0] OWN_ADDRESS_RESET = 8'h00;
  localparam logic [7:0] READ_FILL = 8'hff;

  localparam int CORE_CLK_PERIOD_NS = 50;
  localparam int SCL_PERIOD_NS = 400;
  localparam int SCL_HALF_CYCLES =
    (SCL_PERIOD_NS / 2 + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_addr_lo,
    st_rx,
    st_tx
  } isas_dev_state_t;

  typedef enum logic [2:0] {
    m_idle,
    m_start,
    m_rs_rise,
    m_hold,
    m_low,
    m_high,
    m_stop_low,
    m_stop_high
  } isas_mst_state_t;

  typedef enum logic [1:0] {
    cmd_start,
    cmd_write,
    cmd_read,
    cmd_stop
  } isas_cmd_t;

endpackage

//--- common/isas_bus_if.sv
// Open-drain clock and data wires between the bus master and the slave engine.
// Each party gives output and enable per pin; the wired level is resolved here.
`timescale 1ns/1ps
interface isas_bus_if;
  logic scl_m_out;
  logic scl_m_oe;
  logic sda_m_out;
  logic sda_m_oe;
  logic scl_s_out;
  logic scl_s_oe;
  logic sda_s_out;
  logic sda_s_oe;
  logic scl;
  logic sda;

  assign scl = !((scl_m_oe && !scl_m_out) || (scl_s_oe && !scl_s_out));
  assign sda = !((sda_m_oe && !sda_m_out) || (sda_s_oe && !sda_s_out));

  modport device (input scl, input sda, output scl_s_out, output scl_s_oe,
                  output sda_s_out, output sda_s_oe);
  modport master (input scl, input sda, output scl_m_out, output scl_m_oe,
                  output sda_m_out, output sda_m_oe);
endinterface

//--- hw/isas_slave.sv
// Slave engine with address match, receive, transmit and clock stretching, plus its FIFO.
// Assumes an external master on the wires and software strobes on the core clock.
`timescale 1ns/1ps

module isas_fifo
  import isas_pkg::*;
#(
  parameter int WIDTH = BYTE_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'h1;
  endfunction

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  always_comb
  begin
    count_next = count_reg;
    if (push && !pop)
      count_next = count_reg + 1'h1;
    else if (pop && !push)
      count_next = count_reg - 1'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (clk_en && push)
      mem_reg[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'h1;
      out_valid <= 1'h0;
    end
    else if (clk_en)
    begin
      if (push)
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (pop)
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      count_reg <= count_next;
      in_ready <= count_next != (AW + 1)'(DEPTH);
      out_valid <= count_next != '0;
    end
  end
endmodule

module isas_slave
  import isas_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  isas_bus_if.device bus,
  input wire logic enable,
  input wire logic ten_bit_mode,
  input wire logic receive_stretch_enable,
  input wire logic own_addr_wr,
  input wire logic [7:0] own_addr_wdata,
  input wire logic buf_rd,
  input wire logic event_clr,
  input wire logic overflow_clr,
  input wire logic release_set,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic [7:0] transfer_buffer,
  output logic [7:0] own_address_register,
  output logic buffer_full_flag,
  output logic receive_overflow_flag,
  output logic port_event_flag,
  output logic address_update_flag,
  output logic read_dir,
  output logic clock_release_bit
);
  isas_dev_state_t state_reg;
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_q_reg, sda_q_reg, scl_prev_reg, sda_prev_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_register_reg;
  logic sda_oe_reg, scl_oe_reg;
  logic ten_hi_seen_reg, addr_byte_reg, event_due_reg, ua_hold_reg;
  logic rise, fall, start_c, stop_c, fall8, fall9, rise9;
  logic addr_phase_c, blocked_c, match_c, take_c, nack_c, tx_pop_c, release_clr_c;
  logic fifo_valid;
  logic [7:0] fifo_data;
  isas_dev_state_t next_c;

  function automatic logic filt(input logic s2, input logic s3, input logic q);
    filt = (s2 == s3) ? s3 : q;
  endfunction

  assign bus.scl_s_out = 1'h0;
  assign bus.sda_s_out = 1'h0;
  assign bus.scl_s_oe = scl_oe_reg;
  assign bus.sda_s_oe = sda_oe_reg;

  isas_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
    .in_valid(tx_valid), .in_data(tx_data), .in_ready(tx_ready),
    .out_valid(fifo_valid), .out_data(fifo_data), .out_ready(tx_pop_c));

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_q_reg <= 1'h1;
      sda_q_reg <= 1'h1;
      scl_prev_reg <= 1'h1;
      sda_prev_reg <= 1'h1;
    end
    else if (clk_en)
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
      scl_q_reg <= filt(scl_sync_reg[1], scl_sync_reg[2], scl_q_reg);
      sda_q_reg <= filt(sda_sync_reg[1], sda_sync_reg[2], sda_q_reg);
      scl_prev_reg <= scl_q_reg;
      sda_prev_reg <= sda_q_reg;
    end
  end

  assign rise = scl_q_reg && !scl_prev_reg;
  assign fall = !scl_q_reg && scl_prev_reg;
  assign start_c = scl_q_reg && scl_prev_reg && sda_prev_reg && !sda_q_reg;
  assign stop_c = scl_q_reg && scl_prev_reg && !sda_prev_reg && sda_q_reg;
  assign fall8 = fall && bit_cnt_reg == LAST_DATA_CNT;
  assign fall9 = fall && bit_cnt_reg == ACK_BIT_CNT;
  assign rise9 = rise && bit_cnt_reg == LAST_DATA_CNT;
  assign addr_phase_c = state_reg == st_addr || state_reg == st_addr_lo;
  assign blocked_c = buffer_full_flag || receive_overflow_flag;

  always_comb
  begin
    match_c = 1'h0;
    next_c = state_reg;
    if (state_reg == st_addr && ten_bit_mode)
      match_c = shift_register_reg[7:3] == TEN_BIT_PREFIX
        && shift_register_reg[2:1] == own_address_register[2:1]
        && (!shift_register_reg[0] || ten_hi_seen_reg);
    else if (state_reg == st_addr)
      match_c = shift_register_reg[7:1] == own_address_register[7:1];
    else if (state_reg == st_addr_lo)
      match_c = shift_register_reg == own_address_register;
    if (addr_phase_c)
    begin
      if (!match_c || blocked_c)
        next_c = st_idle;
      else if (shift_register_reg[0] && state_reg == st_addr)
        next_c = st_tx;
      else if (ten_bit_mode && state_reg == st_addr)
        next_c = st_addr_lo;
      else
        next_c = st_rx;
    end
  end

  assign take_c = fall8 && !blocked_c && (addr_phase_c ? match_c : state_reg == st_rx);
  assign nack_c = rise9 && state_reg == st_tx && !addr_byte_reg && sda_q_reg;
  assign tx_pop_c = enable && state_reg == st_tx && !buffer_full_flag && fifo_valid
    && ((bit_cnt_reg == 4'h0 && !scl_q_reg && !fall) || fall9);
  assign release_clr_c = fall9 && ((state_reg == st_tx
    && (addr_byte_reg || (!buffer_full_flag && !tx_pop_c)))
    || (state_reg == st_rx && !addr_byte_reg && receive_stretch_enable
    && buffer_full_flag));

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= st_idle;
      bit_cnt_reg <= 4'h0;
      shift_register_reg <= 8'h00;
      transfer_buffer <= 8'h00;
      sda_oe_reg <= 1'h0;
      read_dir <= 1'h0;
      ten_hi_seen_reg <= 1'h0;
      addr_byte_reg <= 1'h0;
      event_due_reg <= 1'h0;
    end
    else if (clk_en)
    begin
      if (!enable)
      begin
        state_reg <= st_idle;
        sda_oe_reg <= 1'h0;
        ten_hi_seen_reg <= 1'h0;
      end
      else if (start_c)
      begin
        state_reg <= st_addr;
        bit_cnt_reg <= 4'h0;
        sda_oe_reg <= 1'h0;
      end
      else if (stop_c)
      begin
        state_reg <= st_idle;
        sda_oe_reg <= 1'h0;
        ten_hi_seen_reg <= 1'h0;
      end
      else if (state_reg != st_idle)
      begin
        if (rise && bit_cnt_reg != ACK_BIT_CNT)
        begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (state_reg != st_tx && bit_cnt_reg != LAST_DATA_CNT)
            shift_register_reg <= {shift_register_reg[6:0], sda_q_reg};
        end
        if (nack_c)
        begin
          state_reg <= st_idle;
          read_dir <= 1'h0;
        end
        if (fall8)
        begin
          state_reg <= next_c;
          addr_byte_reg <= addr_phase_c;
          event_due_reg <= addr_phase_c ? match_c : 1'h1;
          sda_oe_reg <= take_c;
          if (take_c)
            transfer_buffer <= shift_register_reg;
          if (take_c && addr_phase_c && state_reg == st_addr)
            read_dir <= shift_register_reg[0];
          if (take_c && state_reg == st_addr && ten_bit_mode)
            ten_hi_seen_reg <= 1'h1;
        end
        else if (fall9)
        begin
          bit_cnt_reg <= 4'h0;
          sda_oe_reg <= 1'h0;
        end
        else if (fall && state_reg == st_tx && !addr_byte_reg)
        begin
          shift_register_reg <= {shift_register_reg[6:0], 1'h0};
          sda_oe_reg <= !shift_register_reg[6];
        end
        if (tx_pop_c)
        begin
          shift_register_reg <= fifo_data;
          transfer_buffer <= fifo_data;
          sda_oe_reg <= !fifo_data[7];
          addr_byte_reg <= 1'h0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      own_address_register <= OWN_ADDRESS_RESET;
    else if (clk_en && own_addr_wr)
      own_address_register <= own_addr_wdata;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      buffer_full_flag <= 1'h0;
      receive_overflow_flag <= 1'h0;
      port_event_flag <= 1'h0;
      address_update_flag <= 1'h0;
      clock_release_bit <= CLOCK_RELEASE_RESET;
      ua_hold_reg <= 1'h0;
      scl_oe_reg <= 1'h0;
    end
    else if (clk_en)
    begin
      if (take_c || tx_pop_c)
        buffer_full_flag <= 1'h1;
      else if (buf_rd || nack_c || (fall8 && state_reg == st_tx))
        buffer_full_flag <= 1'h0;
      if (fall8 && state_reg == st_rx && buffer_full_flag)
        receive_overflow_flag <= 1'h1;
      else if (overflow_clr)
        receive_overflow_flag <= 1'h0;
      if (fall9 && event_due_reg && state_reg != st_idle)
        port_event_flag <= 1'h1;
      else if (event_clr)
        port_event_flag <= 1'h0;
      if (take_c && ten_bit_mode && addr_phase_c && !(state_reg == st_addr
          && shift_register_reg[0]))
        address_update_flag <= 1'h1;
      else if (own_addr_wr || nack_c)
        address_update_flag <= 1'h0;
      if (release_clr_c)
        clock_release_bit <= 1'h0;
      else if (release_set)
        clock_release_bit <= 1'h1;
      if (fall9 && addr_byte_reg && address_update_flag)
        ua_hold_reg <= 1'h1;
      else if (!address_update_flag)
        ua_hold_reg <= 1'h0;
      scl_oe_reg <= enable && (!clock_release_bit || ua_hold_reg)
        && (scl_oe_reg || !scl_q_reg);
    end
  end
endmodule

//--- hw/isas_master.sv
// Bus master end: makes the clock by a divider, start, restart, stop and bytes.
// Assumes one command at a time from the user side and honours slave clock holding.
`timescale 1ns/1ps
module isas_master
  import isas_pkg::*;
#(
  parameter int HALF = SCL_HALF_CYCLES
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  isas_bus_if.master bus,
  input wire logic cmd_valid,
  input wire isas_cmd_t cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_nack,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack
);
  localparam int TW = $clog2(HALF + 1);
  isas_mst_state_t state_reg;
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_q_reg, sda_q_reg;
  logic scl_oe_reg, sda_oe_reg;
  logic [TW-1:0] tick_reg;
  logic [3:0] bit_reg;
  logic [8:0] tx_sh_reg;
  logic [7:0] rx_sh_reg;
  logic done_c;
  logic take_c;

  assign bus.scl_m_out = 1'h0;
  assign bus.sda_m_out = 1'h0;
  assign bus.scl_m_oe = scl_oe_reg;
  assign bus.sda_m_oe = sda_oe_reg;
  assign done_c = tick_reg == TW'(HALF - 1);
  assign take_c = cmd_valid && cmd_ready;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_q_reg <= 1'h1;
      sda_q_reg <= 1'h1;
    end
    else if (clk_en)
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
      if (scl_sync_reg[1] == scl_sync_reg[2])
        scl_q_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2])
        sda_q_reg <= sda_sync_reg[2];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= m_idle;
      scl_oe_reg <= 1'h0;
      sda_oe_reg <= 1'h0;
      tick_reg <= '0;
      bit_reg <= 4'h0;
      tx_sh_reg <= 9'h1ff;
      rx_sh_reg <= 8'h00;
      cmd_ready <= 1'h1;
      rsp_valid <= 1'h0;
      rsp_data <= 8'h00;
      rsp_ack <= 1'h0;
    end
    else if (clk_en)
    begin
      rsp_valid <= 1'h0;
      unique case (state_reg)
        m_idle:
        begin
          scl_oe_reg <= 1'h0;
          sda_oe_reg <= 1'h0;
          tick_reg <= '0;
          if (take_c && cmd_op == cmd_start)
          begin
            state_reg <= m_start;
            cmd_ready <= 1'h0;
          end
          else if (take_c)
          begin
            rsp_valid <= 1'h1;
            rsp_ack <= 1'h0;
          end
        end
        m_start:
        begin
          sda_oe_reg <= 1'h1;
          tick_reg <= tick_reg + 1'h1;
          if (done_c)
          begin
            scl_oe_reg <= 1'h1;
            state_reg <= m_hold;
            cmd_ready <= 1'h1;
            rsp_valid <= 1'h1;
            rsp_ack <= 1'h1;
          end
        end
        m_rs_rise:
        begin
          sda_oe_reg <= 1'h0;
          scl_oe_reg <= 1'h0;
          if (scl_q_reg)
            tick_reg <= tick_reg + 1'h1;
          if (scl_q_reg && done_c)
          begin
            tick_reg <= '0;
            state_reg <= m_start;
          end
        end
        m_hold:
        begin
          tick_reg <= '0;
          bit_reg <= 4'h0;
          if (take_c)
          begin
            cmd_ready <= 1'h0;
            unique case (cmd_op)
              cmd_start: state_reg <= m_rs_rise;
              cmd_write:
              begin
                tx_sh_reg <= {cmd_data, 1'h1};
                state_reg <= m_low;
              end
              cmd_read:
              begin
                tx_sh_reg <= {READ_FILL, cmd_nack};
                state_reg <= m_low;
              end
              cmd_stop: state_reg <= m_stop_low;
            endcase
          end
        end
        m_low:
        begin
          sda_oe_reg <= !tx_sh_reg[8];
          tick_reg <= tick_reg + 1'h1;
          if (done_c)
          begin
            tick_reg <= '0;
            scl_oe_reg <= 1'h0;
            state_reg <= m_high;
          end
        end
        m_high:
        begin
          if (scl_q_reg)
            tick_reg <= tick_reg + 1'h1;
          if (scl_q_reg && done_c)
          begin
            tick_reg <= '0;
            scl_oe_reg <= 1'h1;
            tx_sh_reg <= {tx_sh_reg[7:0], 1'h1};
            rx_sh_reg <= {rx_sh_reg[6:0], sda_q_reg};
            bit_reg <= bit_reg + 4'h1;
            state_reg <= m_low;
            if (bit_reg == LAST_DATA_CNT)
            begin
              rsp_valid <= 1'h1;
              rsp_data <= rx_sh_reg;
              rsp_ack <= !sda_q_reg;
              cmd_ready <= 1'h1;
              state_reg <= m_hold;
            end
          end
        end
        m_stop_low:
        begin
          sda_oe_reg <= 1'h1;
          tick_reg <= tick_reg + 1'h1;
          if (done_c)
          begin
            tick_reg <= '0;
            scl_oe_reg <= 1'h0;
            state_reg <= m_stop_high;
          end
        end
        m_stop_high:
        begin
          if (scl_q_reg)
            tick_reg <= tick_reg + 1'h1;
          if (scl_q_reg && done_c)
          begin
            sda_oe_reg <= 1'h0;
            state_reg <= m_idle;
            cmd_ready <= 1'h1;
            rsp_valid <= 1'h1;
            rsp_ack <= 1'h1;
          end
        end
      endcase
    end
  end
endmodule

//--- test/isas_asserts.sv
// Bus checker for the two-wire slave link.
// Assumes it sits beside the bus interface, on the core clock.
`timescale 1ns/1ps
module isas_asserts
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_m_oe,
  input wire logic scl_s_oe,
  input wire logic sda_s_oe
);
  logic [1:0] pin_reg;
  logic [3:0] cnt_reg;
  logic adr_reg, idle_reg;
  wire logic start_w = scl && pin_reg == 2'h3 && !sda;
  wire logic stop_w = scl && pin_reg == 2'h2 && sda;
  wire logic rise_w = scl && !pin_reg[1];
  wire logic addr_bit_w = adr_reg && scl && !rise_w && cnt_reg != 4'h9;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      pin_reg <= 2'h3;
    else
      pin_reg <= {scl, sda};
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_reg <= 4'h0;
    else if (start_w)
      cnt_reg <= 4'h0;
    else if (rise_w)
      cnt_reg <= (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      adr_reg <= 1'h0;
    else if (start_w)
      adr_reg <= 1'h1;
    else if (rise_w && cnt_reg == 4'h9)
      adr_reg <= 1'h0;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      idle_reg <= 1'h1;
    else if (start_w || stop_w)
      idle_reg <= stop_w;
  end

  hold_after_low_a: assert property ($rose(scl_s_oe) |-> !scl && $past(scl_m_oe))
    else $error("clock held early");
  data_on_low_a: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("data moved while clock high");
  stretch_ninth_a: assert property ($rose(scl_s_oe) |-> cnt_reg == 4'h9)
    else $error("hold outside ninth bit");
  addr_bits_free_a: assert property (addr_bit_w |-> !sda_s_oe)
    else $error("data pulled in address bits");
  ack_after_eighth_a: assert property (adr_reg && sda_s_oe |-> cnt_reg >= 4'h8)
    else $error("ack before eighth bit");
  idle_release_a: assert property (idle_reg |-> !sda_s_oe && !scl_s_oe)
    else $error("pull while bus idle");
  addr_no_hold_a: assert property (adr_reg && cnt_reg != 4'h9 |-> !scl_s_oe)
    else $error("hold inside address byte");
  start_clear_a: assert property (start_w |=> !sda_s_oe [*4])
    else $error("data pulled after start");
endmodule

//--- test/i2c_slave_addressing_and_stretch_tb.sv
// Bench joining the master end and slave end on one open-drain bus.
// Assumes the package, the interface and both ends are compiled first.
`timescale 1ns/1ps
module i2c_slave_addressing_and_stretch_tb import isas_pkg::*;;
  logic core_clk, arst_n, cmd_valid, cmd_nack, cmd_ready, rsp_valid, rsp_ack;
  isas_cmd_t cmd_op;
  logic [7:0] cmd_data, rsp_data, own_addr_wdata, tx_data, transfer_buffer, own_address_register;
  logic ten_bit_mode, receive_stretch_enable, tx_valid, tx_ready, buffer_full_flag;
  logic receive_overflow_flag, port_event_flag, address_update_flag, read_dir, clock_release_bit;
  logic [4:0] sw;
  logic slave_en;
  int failures, checked;
  isas_bus_if bus_if ();

  isas_master #(.HALF(8)) isas_master_inst (.core_clk, .arst_n, .clk_en(1'h1), .bus(bus_if),
    .cmd_valid, .cmd_op, .cmd_data, .cmd_nack, .cmd_ready, .rsp_valid, .rsp_data, .rsp_ack);
  isas_slave isas_slave_inst (.core_clk, .arst_n, .clk_en(1'h1), .bus(bus_if), .enable(slave_en),
    .ten_bit_mode, .receive_stretch_enable, .own_addr_wr(sw[4]), .own_addr_wdata,
    .buf_rd(sw[0]), .event_clr(sw[1]), .overflow_clr(sw[2]), .release_set(sw[3]), .tx_valid,
    .tx_data, .tx_ready, .transfer_buffer, .own_address_register, .buffer_full_flag,
    .receive_overflow_flag, .port_event_flag, .address_update_flag, .read_dir, .clock_release_bit);
  isas_asserts isas_asserts_inst (.core_clk, .arst_n, .scl(bus_if.scl), .sda(bus_if.sda),
    .scl_m_oe(bus_if.scl_m_oe), .scl_s_oe(bus_if.scl_s_oe), .sda_s_oe(bus_if.sda_s_oe));

  initial
  begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic pulse(input int k);
    @(negedge core_clk);
    sw[k] = 1'h1;
    @(negedge core_clk);
    sw[k] = 1'h0;
  endtask

  task automatic cmd(input isas_cmd_t op, input logic [7:0] d, input logic nk);
    int n;
    n = 0;
    @(negedge core_clk);
    while (cmd_ready !== 1'h1 && n < 9000)
    begin
      @(negedge core_clk);
      n++;
    end
    cmd_valid = 1'h1;
    cmd_op = op;
    cmd_data = d;
    cmd_nack = nk;
    @(negedge core_clk);
    cmd_valid = 1'h0;
    while (rsp_valid !== 1'h1 && n < 9000)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 9000)
      failures++;
    repeat (8) @(negedge core_clk);
  endtask

  task automatic push(input logic [7:0] first, input int cnt);
    for (int i = 0; i < cnt; i++)
    begin
      @(negedge core_clk);
      tx_valid = 1'h1;
      tx_data = first + 8'(i);
    end
    @(negedge core_clk);
    tx_valid = 1'h0;
  endtask

  task automatic t_write7;
    receive_stretch_enable = 1'h1;
    own_addr_wdata = 8'ha0;
    pulse(4);
    cmd(cmd_start, 8'h00, 1'h0);
    cmd(cmd_write, 8'h30, 1'h0);
    chk("miss", {rsp_ack, port_event_flag}, 2'h0);
    cmd(cmd_start, 8'h00, 1'h0);
    cmd(cmd_write, 8'ha0, 1'h0);
    chk("adr", {rsp_ack, read_dir, transfer_buffer}, 10'h2a0);
    chk("adr fl", {buffer_full_flag, port_event_flag, clock_release_bit}, 3'h7);
    pulse(0);
    chk("rd", {buffer_full_flag, port_event_flag}, 2'h1);
    pulse(1);
    cmd(cmd_write, 8'h5a, 1'h0);
    chk("dat", {rsp_ack, transfer_buffer}, 9'h15a);
    chk("hold", {buffer_full_flag, port_event_flag, clock_release_bit}, 3'h6);
    chk("hold w", bus_if.scl_s_oe, 1'h1);
    pulse(3);
    chk("rel", clock_release_bit, 1'h1);
    cmd(cmd_write, 8'h3c, 1'h0);
    chk("ovf", {rsp_ack, receive_overflow_flag, transfer_buffer}, 10'h15a);
    pulse(0);
    pulse(2);
    pulse(1);
    pulse(3);
    cmd(cmd_stop, 8'h00, 1'h0);
  endtask

  task automatic t_off;
    slave_en = 1'h0;
    cmd(cmd_start, 8'h00, 1'h0);
    cmd(cmd_write, 8'ha0, 1'h0);
    chk("off", {rsp_ack, port_event_flag}, 2'h0);
    slave_en = 1'h1;
    cmd(cmd_stop, 8'h00, 1'h0);
  endtask

  task automatic t_read7;
    receive_stretch_enable = 1'h0;
    push(8'h3a, 3);
    cmd(cmd_start, 8'h00, 1'h0);
    cmd(cmd_write, 8'ha1, 1'h0);
    chk("radr", {rsp_ack, read_dir, clock_release_bit, transfer_buffer}, 11'h6a1);
    pulse(0);
    @(negedge core_clk);
    chk("load", transfer_buffer, 8'h3a);
    pulse(1);
    pulse(3);
    for (int i = 0; i < 3; i++)
    begin
      cmd(cmd_read, 8'h00, 1'h0);
      chk("tx", rsp_data, 8'h3a + 8'(i));
      chk("tx ev", port_event_flag, 1'h1);
      chk("tx rel", clock_release_bit, (i == 2) ? 1'h0 : 1'h1);
      pulse(1);
    end
    push(8'h96, 1);
    pulse(3);
    cmd(cmd_read, 8'h00, 1'h1);
    chk("last", rsp_data, 8'h96);
    chk("nack", {read_dir, clock_release_bit}, 2'h1);
    pulse(1);
    cmd(cmd_stop, 8'h00, 1'h0);
  endtask

  task automatic t_ten;
    ten_bit_mode = 1'h1;
    own_addr_wdata = 8'hf6;
    pulse(4);
    cmd(cmd_start, 8'h00, 1'h0);
    cmd(cmd_write, 8'hf6, 1'h0);
    chk("hi", {rsp_ack, buffer_full_flag, port_event_flag, address_update_flag},
      4'hf);
    chk("hi hold", {bus_if.scl_s_oe, clock_release_bit}, 2'h3);
    own_addr_wdata = 8'h5c;
    pulse(4);
    chk("lo wr", {address_update_flag, own_address_register}, 9'h05c);
    pulse(0);
    pulse(1);
    cmd(cmd_write, 8'h5c, 1'h0);
    chk("lo", {rsp_ack, buffer_full_flag, port_event_flag, address_update_flag},
      4'hf);
    own_addr_wdata = 8'hf6;
    pulse(4);
    chk("lo done", address_update_flag, 1'h0);
    pulse(0);
    pulse(1);
    cmd(cmd_write, 8'h11, 1'h0);
    chk("10 dat", {rsp_ack, transfer_buffer}, 9'h111);
    pulse(0);
    pulse(1);
    push(8'h5e, 1);
    cmd(cmd_start, 8'h00, 1'h0);
    cmd(cmd_write, 8'hf7, 1'h0);
    chk("hi rd", {rsp_ack, address_update_flag, read_dir, clock_release_bit},
      4'ha);
    pulse(0);
    pulse(1);
    pulse(3);
    cmd(cmd_read, 8'h00, 1'h1);
    chk("10 tx", rsp_data, 8'h5e);
    cmd(cmd_stop, 8'h00, 1'h0);
    ten_bit_mode = 1'h0;
  endtask

  task automatic t_fifo;
    push(8'h40, 8);
    chk("fifo", tx_ready, 1'h0);
  endtask

  initial
  begin
    failures = 0;
    checked = 0;
    arst_n = 1'h0;
    {cmd_valid, cmd_nack, ten_bit_mode, receive_stretch_enable, tx_valid, sw} = 10'h000;
    slave_en = 1'h1;
    cmd_op = cmd_start;
    {cmd_data, own_addr_wdata, tx_data} = 24'h000000;
    repeat (6) @(negedge core_clk);
    arst_n = 1'h1;
    chk("rst", {buffer_full_flag, clock_release_bit, tx_ready, own_address_register},
      11'h300);
    t_write7();
    t_off();
    t_read7();
    t_ten();
    t_fifo();
    conclude();
  end

  initial
  begin
    repeat (60000) @(posedge core_clk);
    failures++;
    conclude();
  end
endmodule
